/* File: core/supervisor_defs.svh */
`ifndef SUPERVISOR_DEFS_SVH
`define SUPERVISOR_DEFS_SVH
// Behaviour
// - Reset output low while line is low or supply is below backup cell.
// - Reset held for the reset-active period (50 ms) after line recovers.
// - Enabled watchdog timing out gives a reset pulse of reset-active length.
// - Processor must toggle kick input in time; otherwise reset and status low.
// - Every rising or falling kick transition restarts the timeout count.
// - Kick input at mid level disables the watchdog, no watchdog resets.
// - Watchdog status returns high on the next kick transition after timeout.
// - Watchdog status held high while kick input sits at mid level.
// - Watchdog status forced high whenever the supply-low flag is active.
// - Power-fail flag low while its sense is low or supply below backup.
// - Chip enable passes through while line is good, forced high otherwise.
// - Backup flag high while output rail runs from the backup cell.
// - Supply-low flag follows the line sense with no added delay.
// - Active-high reset output is always the complement of active-low one.
// - Select high: both periods timed from the internal oscillator.
// - Select low: timing taken from rising edges on the timebase input pin.
// - Internal oscillator: timebase input level picks short or long timeout.
// - External clock: 1024 normal, 4096 after reset, 512 reset-active.
// - After any reset the long timeout applies until the first kick edge.
// - Watchdog timer restarts at the end of every reset.

// Clock and internal oscillator
`define CLK_HZ 100000000
`define INT_OSC_HZ 10240

// Periods in time units, as printed
`define RST_ACTIVE_MS 50
`define WD_SHORT_MS 100
`define WD_LONG_MS 1600

// Periods in internal oscillator ticks
`define INT_RST_TICKS (`RST_ACTIVE_MS * `INT_OSC_HZ / 1000)
`define INT_SHORT_TICKS (`WD_SHORT_MS * `INT_OSC_HZ / 1000)
`define INT_LONG_TICKS (`WD_LONG_MS * `INT_OSC_HZ / 1000)

// Periods in external clock ticks
`define EXT_RST_TICKS 512
`define EXT_NORMAL_TICKS 1024
`define EXT_LONG_TICKS 4096

// Register map, byte offsets
`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_COUNT 8'h08
`define CTRL_WD_EN_BIT 0
`define CTRL_RESET_VAL 32'h0000_0001

// Status field positions
`define ST_RESET_BIT 0
`define ST_WDO_BIT 1
`define ST_PFO_BIT 2
`define ST_LOWLINE_BIT 3
`define ST_BACKUP_BIT 4
`define ST_LONG_BIT 5
`define ST_MID_BIT 6
`define ST_STATE_LSB 8

`define HTRANS_NONSEQ_BIT 1
`endif

/* File: core/supervisor_pkg.sv */
package supervisor_pkg;
  typedef enum logic [1:0] {ST_HOLD, ST_STRETCH, ST_RUN} sup_state_e;
  typedef logic [15:0] tick_count_t;
endpackage

/* File: core/supervisor_reset_watchdog.sv */
// The implementer's own choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "supervisor_defs.svh"
module supervisor_reset_watchdog #(
  parameter int unsigned INT_DIV = `CLK_HZ / `INT_OSC_HZ
) (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Comparator decisions, high means below threshold
  input wire logic LINE_SENSE_BELOW,
  input wire logic POWERFAIL_SENSE_IN,
  input wire logic SUPPLY_BELOW_BACKUP,
  // Watchdog kick, level and mid-level state
  input wire logic WATCHDOG_KICK_IN,
  input wire logic WATCHDOG_KICK_MID,
  // Timebase
  input wire logic TIMEBASE_SELECT,
  input wire logic TIMEBASE_INPUT,
  // Chip enable gating
  input wire logic CHIP_ENABLE_IN_N,
  output logic CHIP_ENABLE_OUT_N,
  // Supervisor outputs
  output logic RESET_N,
  output logic RESET,
  output logic WATCHDOG_STATUS_N,
  output logic POWERFAIL_FLAG_N,
  output logic LOW_LINE_N,
  output logic ON_BACKUP_FLAG,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);
  timebase_if tb();
  assign tb.select_internal = TIMEBASE_SELECT;
  assign tb.osc_level = TIMEBASE_INPUT;

  timebase_tick #(.DIV(INT_DIV)) u_tick (
    .clk(CLK_SYS),
    .rst(RST),
    .tb(tb.src)
  );

  supervisor_pkg::sup_state_e state;
  supervisor_pkg::sup_state_e next_state;
  supervisor_pkg::tick_count_t rst_cnt;
  supervisor_pkg::tick_count_t next_rst_cnt;
  supervisor_pkg::tick_count_t wd_cnt;
  supervisor_pkg::tick_count_t next_wd_cnt;
  supervisor_pkg::tick_count_t rst_period;
  supervisor_pkg::tick_count_t wd_period;
  logic long_mode;
  logic next_long_mode;
  logic kick_prev;
  logic kick_edge;
  logic wd_on;
  logic fault;
  logic watchdog_status_n;
  logic next_wdo;
  logic next_reset_n;
  logic next_pfo_n;
  logic next_low_line_n;
  logic next_ce_out_n;
  logic next_backup;

  // Bus state
  logic [31:0] ctrl;
  logic [31:0] next_ctrl;
  logic wr_pend;
  logic next_wr_pend;
  logic [7:0] wr_addr;
  logic [7:0] next_wr_addr;
  logic [31:0] next_hrdata;
  logic [31:0] status_word;
  logic [31:0] read_mux;
  logic bus_take;

  // Period selection
  always_comb begin
    if (TIMEBASE_SELECT) begin
      rst_period = 16'(`INT_RST_TICKS);
      if (long_mode || TIMEBASE_INPUT) begin
        wd_period = 16'(`INT_LONG_TICKS);
      end else begin
        wd_period = 16'(`INT_SHORT_TICKS);
      end
    end else begin
      rst_period = 16'(`EXT_RST_TICKS);
      if (long_mode) begin
        wd_period = 16'(`EXT_LONG_TICKS);
      end else begin
        wd_period = 16'(`EXT_NORMAL_TICKS);
      end
    end
  end

  assign fault = LINE_SENSE_BELOW | SUPPLY_BELOW_BACKUP;
  assign kick_edge = ~WATCHDOG_KICK_MID & (WATCHDOG_KICK_IN ^ kick_prev);
  assign wd_on = ~WATCHDOG_KICK_MID & ctrl[`CTRL_WD_EN_BIT];

  // Reset and watchdog sequencing
  always_comb begin
    next_state = state;
    next_rst_cnt = rst_cnt;
    next_wd_cnt = wd_cnt;
    next_long_mode = long_mode;
    next_wdo = watchdog_status_n;
    if (kick_edge) begin
      next_wdo = 1'b1;
    end
    case (state)
      supervisor_pkg::ST_HOLD: begin
        next_rst_cnt = 16'h0000;
        if (!fault) begin
          next_state = supervisor_pkg::ST_STRETCH;
        end
      end
      supervisor_pkg::ST_STRETCH: begin
        if (fault) begin
          next_state = supervisor_pkg::ST_HOLD;
        end else if (tb.tick) begin
          if (rst_cnt >= rst_period - 16'h0001) begin
            next_state = supervisor_pkg::ST_RUN;
            next_wd_cnt = 16'h0000;
            next_long_mode = 1'b1;
          end else begin
            next_rst_cnt = rst_cnt + 16'h0001;
          end
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (fault) begin
          next_state = supervisor_pkg::ST_HOLD;
        end else if (kick_edge) begin
          next_wd_cnt = 16'h0000;
          next_long_mode = 1'b0;
        end else if (!wd_on) begin
          next_wd_cnt = 16'h0000;
        end else if (tb.tick) begin
          if (wd_cnt >= wd_period - 16'h0001) begin
            next_state = supervisor_pkg::ST_STRETCH;
            next_rst_cnt = 16'h0000;
            next_wdo = 1'b0;
          end else begin
            next_wd_cnt = wd_cnt + 16'h0001;
          end
        end
      end
      default: begin
        next_state = supervisor_pkg::ST_HOLD;
      end
    endcase
    if (WATCHDOG_KICK_MID) begin
      next_wdo = 1'b1;
    end
    if (LINE_SENSE_BELOW) begin
      next_wdo = 1'b1;
    end
    next_reset_n = (next_state == supervisor_pkg::ST_RUN);
    next_pfo_n = ~(POWERFAIL_SENSE_IN | SUPPLY_BELOW_BACKUP);
    next_low_line_n = ~LINE_SENSE_BELOW;
    next_ce_out_n = LINE_SENSE_BELOW | CHIP_ENABLE_IN_N;
    next_backup = SUPPLY_BELOW_BACKUP;
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      state <= supervisor_pkg::ST_STRETCH;
      rst_cnt <= 16'h0000;
      wd_cnt <= 16'h0000;
      long_mode <= 1'b1;
      kick_prev <= 1'b0;
      watchdog_status_n <= 1'b1;
      RESET_N <= 1'b0;
      RESET <= 1'b1;
      WATCHDOG_STATUS_N <= 1'b1;
      POWERFAIL_FLAG_N <= 1'b1;
      LOW_LINE_N <= 1'b1;
      CHIP_ENABLE_OUT_N <= 1'b1;
      ON_BACKUP_FLAG <= 1'b0;
    end else begin
      state <= next_state;
      rst_cnt <= next_rst_cnt;
      wd_cnt <= next_wd_cnt;
      long_mode <= next_long_mode;
      kick_prev <= WATCHDOG_KICK_IN;
      watchdog_status_n <= next_wdo;
      RESET_N <= next_reset_n;
      RESET <= ~next_reset_n;
      WATCHDOG_STATUS_N <= next_wdo;
      POWERFAIL_FLAG_N <= next_pfo_n;
      LOW_LINE_N <= next_low_line_n;
      CHIP_ENABLE_OUT_N <= next_ce_out_n;
      ON_BACKUP_FLAG <= next_backup;
    end
  end

  // Register read data
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`ST_RESET_BIT] = ~RESET_N;
    status_word[`ST_WDO_BIT] = watchdog_status_n;
    status_word[`ST_PFO_BIT] = POWERFAIL_FLAG_N;
    status_word[`ST_LOWLINE_BIT] = LOW_LINE_N;
    status_word[`ST_BACKUP_BIT] = ON_BACKUP_FLAG;
    status_word[`ST_LONG_BIT] = long_mode;
    status_word[`ST_MID_BIT] = WATCHDOG_KICK_MID;
    status_word[`ST_STATE_LSB +: 2] = state;
    case (HADDR[7:0])
      `REG_CTRL: read_mux = ctrl;
      `REG_STATUS: read_mux = status_word;
      `REG_COUNT: read_mux = {16'h0000, wd_cnt};
      default: read_mux = 32'h0000_0000;
    endcase
  end

  // AHB-Lite slave, zero wait states
  assign bus_take = HSEL & HREADY & HTRANS[`HTRANS_NONSEQ_BIT];

  always_comb begin
    next_ctrl = ctrl;
    next_wr_pend = bus_take & HWRITE;
    next_wr_addr = HADDR[7:0];
    next_hrdata = HRDATA;
    if (wr_pend && wr_addr == `REG_CTRL) begin
      next_ctrl = {31'h0000_0000, HWDATA[`CTRL_WD_EN_BIT]};
    end
    if (bus_take && !HWRITE) begin
      next_hrdata = read_mux;
    end
  end

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      ctrl <= `CTRL_RESET_VAL;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      HRDATA <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end else begin
      ctrl <= next_ctrl;
      wr_pend <= next_wr_pend;
      wr_addr <= next_wr_addr;
      HRDATA <= next_hrdata;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
    end
  end
endmodule

/* File: core/timebase_if.sv */
`timescale 1ns/1ps
interface timebase_if;
  logic select_internal;
  logic osc_level;
  logic tick;
  modport src (input select_internal, input osc_level, output tick);
  modport user (output select_internal, output osc_level, input tick);
endinterface

/* File: core/timebase_tick.sv */
`timescale 1ns/1ps
module timebase_tick #(
  parameter int unsigned DIV = 9765
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Timebase
  timebase_if.src tb
);
  logic [15:0] div_cnt;
  logic [15:0] next_div_cnt;
  logic osc_prev;
  logic tick;
  logic next_tick;

  always_comb begin
    next_div_cnt = div_cnt + 16'h0001;
    next_tick = 1'b0;
    if (tb.select_internal) begin
      if (div_cnt >= 16'(DIV - 1)) begin
        next_div_cnt = 16'h0000;
        next_tick = 1'b1;
      end
    end else begin
      next_div_cnt = 16'h0000;
      next_tick = tb.osc_level & ~osc_prev;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 16'h0000;
      osc_prev <= 1'b0;
      tick <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      osc_prev <= tb.osc_level;
      tick <= next_tick;
    end
  end

  assign tb.tick = tick;
endmodule

/* File: sim/cpu_partner.sv */
`timescale 1ns/1ps
module cpu_partner #(
  parameter int GAP = 1500
) (
  // Clock and reset seen by the processor
  input wire logic clk,
  input wire logic reset_n,
  // Stall and kick port
  input wire logic stall,
  output logic kick
);
  int cnt = 0;
  // Held in reset or stalled: port stays put
  initial begin
    kick = 1'b0;
    forever begin
      @(posedge clk);
      cnt <= (!reset_n || stall || cnt == GAP - 1) ? 0 : cnt + 1;
      if (reset_n && !stall && cnt == GAP - 1) begin
        kick <= !kick;
      end
    end
  end
endmodule

/* File: sim/supervisor_reset_watchdog_sva.sv */
`timescale 1ns/1ps
module sup_checker (
  // Clock and reset
  input wire logic CLK_SYS,
  input wire logic RST,
  // Inputs
  input wire logic LINE_SENSE_BELOW,
  input wire logic POWERFAIL_SENSE_IN,
  input wire logic SUPPLY_BELOW_BACKUP,
  input wire logic WATCHDOG_KICK_MID,
  input wire logic CHIP_ENABLE_IN_N,
  // Outputs
  input wire logic CHIP_ENABLE_OUT_N,
  input wire logic RESET_N,
  input wire logic RESET,
  input wire logic WATCHDOG_STATUS_N,
  input wire logic POWERFAIL_FLAG_N,
  input wire logic LOW_LINE_N,
  input wire logic ON_BACKUP_FLAG
);
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (RST);
  a_reset_pair: assert property (
    RESET == !RESET_N)
    else $error("reset pair");
  a_fault_reset: assert property (
    LINE_SENSE_BELOW || SUPPLY_BELOW_BACKUP |=> !RESET_N)
    else $error("no reset on fault");
  a_low_line: assert property (
    !$past(RST) |-> LOW_LINE_N == !$past(LINE_SENSE_BELOW))
    else $error("low line flag");
  a_ce_gate: assert property (
    !$past(RST) |->
    CHIP_ENABLE_OUT_N == $past(CHIP_ENABLE_IN_N || LINE_SENSE_BELOW))
    else $error("chip enable gate");
  a_pfail_flag: assert property (
    !$past(RST) |->
    POWERFAIL_FLAG_N == !$past(POWERFAIL_SENSE_IN || SUPPLY_BELOW_BACKUP))
    else $error("power fail flag");
  a_backup_flag: assert property (
    !$past(RST) |-> ON_BACKUP_FLAG == $past(SUPPLY_BELOW_BACKUP))
    else $error("backup flag");
  a_wdo_mid: assert property (
    !$past(RST) && $past(WATCHDOG_KICK_MID) |-> WATCHDOG_STATUS_N)
    else $error("status low at mid");
  a_wdo_line: assert property (
    !$past(RST) && $past(LINE_SENSE_BELOW) |-> WATCHDOG_STATUS_N)
    else $error("status low at low line");
endmodule
bind supervisor_reset_watchdog sup_checker sup_checker_i (.CLK_SYS(CLK_SYS),
  .RST(RST), .LINE_SENSE_BELOW(LINE_SENSE_BELOW),
  .POWERFAIL_SENSE_IN(POWERFAIL_SENSE_IN),
  .SUPPLY_BELOW_BACKUP(SUPPLY_BELOW_BACKUP),
  .WATCHDOG_KICK_MID(WATCHDOG_KICK_MID), .CHIP_ENABLE_IN_N(CHIP_ENABLE_IN_N),
  .CHIP_ENABLE_OUT_N(CHIP_ENABLE_OUT_N), .RESET_N(RESET_N), .RESET(RESET),
  .WATCHDOG_STATUS_N(WATCHDOG_STATUS_N), .POWERFAIL_FLAG_N(POWERFAIL_FLAG_N),
  .LOW_LINE_N(LOW_LINE_N), .ON_BACKUP_FLAG(ON_BACKUP_FLAG));

/* File: sim/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk, rst, line, powerfail_sense_in, sup, mid, tsel, ce_in, stall, kick;
  logic tin = 1'b0;
  logic hsel, hwrite, ce_out, rst_n, rst_h, wdo_n, pfo_n, low_n, bat;
  logic hrdy, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r, v, seed;
  int fails, checks, nres, n, m, k;
  supervisor_reset_watchdog #(.INT_DIV(4)) supervisor_reset_watchdog_i (
    .CLK_SYS(clk), .RST(rst), .LINE_SENSE_BELOW(line),
    .POWERFAIL_SENSE_IN(powerfail_sense_in), .SUPPLY_BELOW_BACKUP(sup),
    .WATCHDOG_KICK_IN(kick), .WATCHDOG_KICK_MID(mid),
    .TIMEBASE_SELECT(tsel), .TIMEBASE_INPUT(tin),
    .CHIP_ENABLE_IN_N(ce_in), .CHIP_ENABLE_OUT_N(ce_out),
    .RESET_N(rst_n), .RESET(rst_h), .WATCHDOG_STATUS_N(wdo_n),
    .POWERFAIL_FLAG_N(pfo_n), .LOW_LINE_N(low_n), .ON_BACKUP_FLAG(bat),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp));
  cpu_partner cpu_partner_i (.clk(clk), .reset_n(rst_n), .stall(stall),
    .kick(kick));
  initial begin
    clk = 1'b0;
    forever #5 clk = !clk;
  end
  // External timebase, one tick per two cycles; low for internal short
  always @(posedge clk) tin <= tsel ? 1'b0 : !tin;
  always @(negedge rst_n) nres++;
  initial begin
    #700000;
    fails++;
    tally_and_finish();
  end
  task automatic check(input string s, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [31:0] a, d);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    r = hrdata;
  endtask
  task automatic wait_sig(input logic rel);
    n = 0;
    while ((rel ? rst_n : !wdo_n) !== 1'b1 && n < 20000) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  initial begin
    seed = 32'h1b45df37;
    {rst, line, powerfail_sense_in, sup, mid, tsel, ce_in, stall} = 8'h80;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = {7'h2, 64'h0};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    wait_sig(1'b1);
    check("por", 32'(n > 1019 && n < 1041), 1);
    bus(1'b0, 32'h0, 0);
    check("ctrl", r, 32'h1);
    bus(1'b1, 32'h0, 0);
    bus(1'b0, 32'h0, 0);
    check("ctrl_wr", r, 0);
    bus(1'b1, 32'h0, 1);
    bus(1'b0, 32'h40, 0);
    check("unmap", r, 0);
    repeat (12) begin
      v = $random(seed);
      {powerfail_sense_in, sup, ce_in, line} <= v[3:0];
      repeat (3) @(posedge clk);
      check("pfo", 32'(pfo_n), 32'(!(v[3] | v[2])));
      check("ce", 32'(ce_out), 32'(v[1] | v[0]));
      check("low", 32'(low_n), 32'(!v[0]));
      check("bat", 32'(bat), 32'(v[2]));
      if (v[2] | v[0]) check("rst", 32'(rst_n), 0);
      if (v[2] | v[0]) check("rst_h", 32'(rst_h), 1);
      bus(1'b0, 32'h4, 0);
      check("st", 32'(r[4:2]), 32'({v[2], !v[0], !(v[3] | v[2])}));
    end
    {stall, line, sup} <= 3'b110;
    repeat (2) @(posedge clk);
    line <= 1'b0;
    wait_sig(1'b1);
    check("stretch", 32'(n > 1019 && n < 1041), 1);
    wait_sig(1'b0);
    check("long", 32'(n > 8184 && n < 8206), 1);
    wait_sig(1'b1);
    check("pulse", 32'(n > 1014 && n < 1036), 1);
    stall <= 1'b0;
    repeat (1510) @(posedge clk);
    check("wdo_back", 32'(wdo_n), 1);
    k = nres;
    repeat (6000) @(posedge clk);
    check("kept", 32'(nres), 32'(k));
    m = cpu_partner_i.cnt;
    stall <= 1'b1;
    wait_sig(1'b0);
    check("short", 32'(n + m > 2039 && n + m < 2066), 1);
    wait_sig(1'b1);
    mid <= 1'b1;
    k = nres;
    repeat (12000) @(posedge clk);
    check("mid", 32'(nres), 32'(k));
    check("mid_wdo", 32'(wdo_n), 1);
    // Internal oscillator: reset stretch, then short timeout after a kick
    {mid, tsel, line} <= 3'b011;
    repeat (2) @(posedge clk);
    line <= 1'b0;
    wait_sig(1'b1);
    check("int_stretch", 32'(n > 2043 && n < 2058), 1);
    k = kick;
    stall <= 1'b0;
    while (kick === k) @(posedge clk);
    stall <= 1'b1;
    wait_sig(1'b0);
    check("int_short", 32'(n > 4088 && n < 4108), 1);
    tally_and_finish();
  end
endmodule
